// ### src/cic_core.sv
/*
  charger input control logic: adapter validity, lockout, inrush blanking,
  thermal priority, safety timer rate, thermistor zones, step charge and an
  ahb-lite register slave. assumes analog comparators on plain input pins,
  one clock hclk at 100 MHz, a single ahb-lite master.
*/
`timescale 1ns/1ps
`include "cic_defs.svh"

// How it works
// - overvoltage opens adapter path, core stays powered
// - lockout entry raises host event
// - invalid input: charger off, load switch closed
// - input below cell or detect level is invalid
// - inrush blanking forces maximum limit, then reverts
// - die hot: charge current cut first
// - die shutdown: no adapter current drawn
// - load or thermal limit with current below half: timer half rate
// - load or thermal limit with current below fifth: timer stops
// - precharge and termination as fast-charge percentages
// - thermistor classified into exactly one zone
// - cold, hot or missing thermistor inhibit charge
// - per-zone two-bit voltage cut applied
// - per-zone current cut applied
// - zone permit may inhibit cool and warm
// - above step threshold, current to step percentage
// - hysteresis before restoring full current
// - step percentage full disables step reduction
// - lower of zone and step current applies
// - charger state readable by host
// - overload lowers charge to protect load rail
// - interrupt low until host reads events
module cic_core
  import cic_pkg::*;
#(
  parameter int TICK_CYC = `CIC_TICK_CYC
)(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // analog comparator inputs, asynchronous
  input  wire logic        adapter_ov,
  input  wire logic        adapter_neg,
  input  wire logic        adapter_below_cell,
  input  wire logic        adapter_below_det,
  input  wire logic        inrush_event,
  input  wire logic        die_chg_lim,
  input  wire logic        die_chg_shdn,
  input  wire logic        load_rail_limit,
  input  wire logic        chg_below_half,
  input  wire logic        chg_below_fifth,
  input  wire logic        therm_absent,
  input  wire logic [3:0]  therm_cmp,
  input  wire logic        cell_above_step,
  input  wire logic        cell_below_hys,
  input  wire logic        cell_above_pre,
  input  wire logic        chg_below_term,
  // analog control outputs
  output logic             adapter_path_on,
  output logic             load_switch_closed,
  output logic             charger_on,
  output logic             ilim_max,
  output logic      [2:0]  ilim_sel,
  output logic             charge_cut_thermal,
  output logic             charge_cut_load,
  output logic      [3:0]  load_rail_floor,
  output logic      [1:0]  vreg_cut,
  output logic      [2:0]  fchg_pct,
  output logic      [2:0]  pchg_pct,
  output logic      [2:0]  term_pct,
  output logic             safety_tick,
  output logic             irq_n
);

  localparam int NSYNC = 19;

  logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, st_reg;
  logic [NSYNC-1:0] raw;
  assign raw = {adapter_ov, adapter_neg, adapter_below_cell, adapter_below_det,
                inrush_event, die_chg_lim, die_chg_shdn, load_rail_limit,
                chg_below_half, chg_below_fifth, therm_absent, therm_cmp,
                cell_above_step, cell_below_hys, cell_above_pre, chg_below_term};

  // three stages; a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++)
    begin : g_sync
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          s1_reg[g] <= 1'b0;
          s2_reg[g] <= 1'b0;
          s3_reg[g] <= 1'b0;
          st_reg[g] <= 1'b0;
        end
        else
        begin
          s1_reg[g] <= raw[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g])
            st_reg[g] <= s3_reg[g];
        end
      end
    end
  endgenerate

  logic       ov_s, neg_s, bcell_s, bdet_s, inrush_s, tlim_s, tshdn_s, lrl_s;
  logic       half_s, fifth_s, tabs_s, step_hi_s, hys_lo_s, pre_s, term_s;
  logic [3:0] tcmp_s;
  assign {ov_s, neg_s, bcell_s, bdet_s, inrush_s, tlim_s, tshdn_s, lrl_s,
          half_s, fifth_s, tabs_s, tcmp_s, step_hi_s, hys_lo_s, pre_s,
          term_s} = st_reg;

  // registers
  logic [31:0] ctrl_reg, zonev_reg, zonei_reg, step_reg, mask_reg;
  logic [2:0]  event_reg;
  logic [31:0] timer_reg;
  // ctrl: [2:0] ilim, [7:3] blank, [11:8] floor, [12] charge enable,
  //       [13] thermistor enable, [14] permit cool, [15] permit warm,
  //       [18:16] precharge pct, [21:19] term pct
  logic [2:0] ilim_set;
  logic [4:0] blank_set;
  logic       chg_en, thm_en, permit_cool, permit_warm;
  assign ilim_set    = ctrl_reg[2:0];
  assign blank_set   = ctrl_reg[7:3];
  assign chg_en      = ctrl_reg[12];
  assign thm_en      = ctrl_reg[13];
  assign permit_cool = ctrl_reg[14];
  assign permit_warm = ctrl_reg[15];

  // ahb address phase capture
  logic       wr_pend_reg, rd_pend_reg;
  logic [7:0] addr_reg;
  logic       take;
  assign take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
      if (take)
        addr_reg <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg  <= `CIC_CTRL_RST;
      zonev_reg <= `CIC_ZONEV_RST;
      zonei_reg <= `CIC_ZONEI_RST;
      step_reg  <= `CIC_STEP_RST;
      mask_reg  <= `CIC_MASK_RST;
    end
    else if (wr_pend_reg)
    begin
      case (addr_reg)
        `CIC_OFS_CTRL:  ctrl_reg  <= {10'h000, hwdata[21:0]};
        `CIC_OFS_ZONEV: zonev_reg <= {26'h0000000, hwdata[5:0]};
        `CIC_OFS_ZONEI: zonei_reg <= {20'h00000, hwdata[11:0]};
        `CIC_OFS_STEP:  step_reg  <= {20'h00000, hwdata[11:0]};
        `CIC_OFS_MASK:  mask_reg  <= {29'h00000000, hwdata[2:0]};
        default:        ;
      endcase
    end
  end

  // thermistor zone from four ordered comparators
  cic_zone_t zone;
  always_comb
  begin
    if (!tcmp_s[0])
      zone = CIC_ZONE_COLD;
    else if (!tcmp_s[1])
      zone = CIC_ZONE_COOL;
    else if (!tcmp_s[2])
      zone = CIC_ZONE_ROOM;
    else if (!tcmp_s[3])
      zone = CIC_ZONE_WARM;
    else
      zone = CIC_ZONE_HOT;
  end

  logic zone_inhibit;
  logic [1:0] zone_vcut;
  logic [2:0] zone_icut;
  always_comb
  begin
    zone_inhibit = 1'b0;
    zone_vcut    = 2'h0;
    zone_icut    = `CIC_PCT_FULL;
    if (thm_en)
    begin
      case (zone)
        CIC_ZONE_COOL:
        begin
          zone_inhibit = !permit_cool;
          zone_vcut    = zonev_reg[1:0];
          zone_icut    = zonei_reg[2:0];
        end
        CIC_ZONE_ROOM:
        begin
          zone_vcut = zonev_reg[3:2];
          zone_icut = zonei_reg[6:4];
        end
        CIC_ZONE_WARM:
        begin
          zone_inhibit = !permit_warm;
          zone_vcut    = zonev_reg[5:4];
          zone_icut    = zonei_reg[10:8];
        end
        default: zone_inhibit = 1'b1;
      endcase
      if (tabs_s)
        zone_inhibit = 1'b1;
    end
  end

  // step charge with hysteresis; step: [2:0] pct, [11:8] threshold code
  logic step_act_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      step_act_reg <= 1'b0;
    else if (step_reg[2:0] == `CIC_PCT_FULL)
      step_act_reg <= 1'b0;
    else if (step_hi_s)
      step_act_reg <= 1'b1;
    else if (hys_lo_s)
      step_act_reg <= 1'b0;
  end

  logic [2:0] step_icut, fchg_next;
  assign step_icut = step_act_reg ? step_reg[2:0] : `CIC_PCT_FULL;
  assign fchg_next = (step_icut < zone_icut) ? step_icut : zone_icut;

  logic input_bad;
  assign input_bad = ov_s || neg_s || bcell_s || bdet_s;

  // inrush blanking counter
  logic [12:0] blank_cnt_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      blank_cnt_reg <= 13'h0000;
    else if (inrush_s && !input_bad)
      blank_cnt_reg <= 13'(blank_set * `CIC_BLANK_UNIT_CYC);
    else if (blank_cnt_reg != 13'h0000)
      blank_cnt_reg <= blank_cnt_reg - 13'h0001;
  end

  // charger state
  cic_state_t state_reg;
  logic       chg_allowed;
  assign chg_allowed = chg_en && !input_bad && !zone_inhibit && !tshdn_s;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= CIC_ST_OFF;
    else
    begin
      case (state_reg)
        CIC_ST_OFF:
          if (chg_allowed)
            state_reg <= pre_s ? CIC_ST_FAST : CIC_ST_PRE;
        CIC_ST_PRE:
          if (!chg_allowed)
            state_reg <= zone_inhibit ? CIC_ST_SUSPEND : CIC_ST_OFF;
          else if (pre_s)
            state_reg <= CIC_ST_FAST;
        CIC_ST_FAST:
          if (!chg_allowed)
            state_reg <= zone_inhibit ? CIC_ST_SUSPEND : CIC_ST_OFF;
          else if (term_s)
            state_reg <= CIC_ST_DONE;
        CIC_ST_SUSPEND:
          if (!chg_en || input_bad)
            state_reg <= CIC_ST_OFF;
          else if (chg_allowed)
            state_reg <= CIC_ST_PRE;
        CIC_ST_DONE:
          if (!chg_en || input_bad)
            state_reg <= CIC_ST_OFF;
        default:
          state_reg <= CIC_ST_OFF;
      endcase
    end
  end

  logic charging;
  assign charging = (state_reg == CIC_ST_PRE) || (state_reg == CIC_ST_FAST);

  // safety timer rate and prescaler
  cic_rate_t rate;
  always_comb
  begin
    if ((lrl_s || tlim_s) && fifth_s)
      rate = CIC_RATE_STOP;
    else if ((lrl_s || tlim_s) && half_s)
      rate = CIC_RATE_HALF;
    else
      rate = CIC_RATE_FULL;
  end

  logic [31:0] pres_reg;
  logic        half_ph_reg, tick;
  assign tick = charging && (rate != CIC_RATE_STOP) && (pres_reg == 32'(TICK_CYC - 1));
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pres_reg    <= 32'h0000_0000;
      half_ph_reg <= 1'b0;
      timer_reg   <= 32'h0000_0000;
    end
    else if (!charging)
    begin
      pres_reg  <= 32'h0000_0000;
      timer_reg <= 32'h0000_0000;
    end
    else if (rate != CIC_RATE_STOP)
    begin
      pres_reg <= tick ? 32'h0000_0000 : pres_reg + 32'h0000_0001;
      if (tick)
      begin
        half_ph_reg <= !half_ph_reg;
        if (rate == CIC_RATE_FULL || half_ph_reg)
          timer_reg <= timer_reg + 32'h0000_0001;
      end
    end
  end

  // events: [0] lockout entry, [1] input invalid, [2] state change
  logic       ov_d_reg, bad_d_reg;
  cic_state_t st_d_reg;
  logic [2:0] ev_set;
  logic       rd_event;
  assign ev_set   = {state_reg != st_d_reg, input_bad && !bad_d_reg,
                     ov_s && !ov_d_reg};
  assign rd_event = rd_pend_reg && (addr_reg == `CIC_OFS_EVENT);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ov_d_reg  <= 1'b0;
      bad_d_reg <= 1'b0;
      st_d_reg  <= CIC_ST_OFF;
      event_reg <= 3'h0;
    end
    else
    begin
      ov_d_reg  <= ov_s;
      bad_d_reg <= input_bad;
      st_d_reg  <= state_reg;
      // set wins over the clear of a read
      event_reg <= (rd_event ? 3'h0 : event_reg) | ev_set;
    end
  end

  logic [31:0] rd_mux;
  always_comb
  begin
    case (addr_reg)
      `CIC_OFS_CTRL:   rd_mux = ctrl_reg;
      `CIC_OFS_ZONEV:  rd_mux = zonev_reg;
      `CIC_OFS_ZONEI:  rd_mux = zonei_reg;
      `CIC_OFS_STEP:   rd_mux = step_reg;
      `CIC_OFS_STATUS: rd_mux = {20'h00000, step_act_reg, 3'(zone), 1'b0,
                                 3'(state_reg), 4'h0};
      `CIC_OFS_EVENT:  rd_mux = {29'h00000000, event_reg};
      `CIC_OFS_MASK:   rd_mux = mask_reg;
      `CIC_OFS_TIMER:  rd_mux = timer_reg;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // registered outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata             <= 32'h0000_0000;
      hreadyout          <= 1'b1;
      hresp              <= 1'b0;
      adapter_path_on    <= 1'b0;
      load_switch_closed <= 1'b1;
      charger_on         <= 1'b0;
      ilim_max           <= 1'b0;
      ilim_sel           <= 3'h0;
      charge_cut_thermal <= 1'b0;
      charge_cut_load    <= 1'b0;
      load_rail_floor    <= 4'h0;
      vreg_cut           <= 2'h0;
      fchg_pct           <= `CIC_PCT_FULL;
      pchg_pct           <= 3'h0;
      term_pct           <= 3'h0;
      safety_tick        <= 1'b0;
      irq_n              <= 1'b1;
    end
    else
    begin
      hrdata             <= rd_mux;
      hreadyout          <= !(take && !hwrite);
      hresp              <= 1'b0;
      adapter_path_on    <= !input_bad && !tshdn_s;
      load_switch_closed <= input_bad || tshdn_s || lrl_s;
      charger_on         <= charging && !input_bad && !tshdn_s;
      ilim_max           <= blank_cnt_reg != 13'h0000;
      ilim_sel           <= (blank_cnt_reg != 13'h0000) ? `CIC_ILIM_MAX : ilim_set;
      charge_cut_thermal <= tlim_s;
      charge_cut_load    <= lrl_s;
      load_rail_floor    <= ctrl_reg[11:8];
      vreg_cut           <= zone_vcut;
      fchg_pct           <= fchg_next;
      pchg_pct           <= ctrl_reg[18:16];
      term_pct           <= ctrl_reg[21:19];
      safety_tick        <= tick;
      irq_n              <= ~|((event_reg | ev_set) & mask_reg[2:0]);
    end
  end

endmodule

// ### src/cic_defs.svh
/*
  register offsets, reset values, timing counts and full-scale codes of the
  charger input control block. assumes inclusion by bare name.
*/
`ifndef CIC_DEFS_SVH
`define CIC_DEFS_SVH

`define CIC_OFS_CTRL      8'h00
`define CIC_OFS_ZONEV     8'h04
`define CIC_OFS_ZONEI     8'h08
`define CIC_OFS_STEP      8'h0C
`define CIC_OFS_STATUS    8'h10
`define CIC_OFS_EVENT     8'h14
`define CIC_OFS_MASK      8'h18
`define CIC_OFS_TIMER     8'h1C

`define CIC_CTRL_RST      32'h0000_0C03
`define CIC_ZONEV_RST     32'h0000_0000
`define CIC_ZONEI_RST     32'h0000_0777
`define CIC_STEP_RST      32'h0000_0700
`define CIC_MASK_RST      32'h0000_0000

`define CIC_BLANK_UNIT_NS 1000
`define CIC_CLK_NS        10
`define CIC_BLANK_UNIT_CYC ((`CIC_BLANK_UNIT_NS + `CIC_CLK_NS - 1) / `CIC_CLK_NS)
`define CIC_TICK_CYC      1000

`define CIC_PCT_FULL      3'h7
`define CIC_ILIM_MAX      3'h7

`endif

// ### src/cic_pkg.sv
/*
  types of the charger input control block. assumes nothing.
*/
package cic_pkg;
  typedef enum {CIC_ZONE_COLD, CIC_ZONE_COOL, CIC_ZONE_ROOM, CIC_ZONE_WARM,
                CIC_ZONE_HOT} cic_zone_t;
  typedef enum {CIC_ST_OFF, CIC_ST_PRE, CIC_ST_FAST, CIC_ST_DONE,
                CIC_ST_SUSPEND, CIC_ST_FAULT} cic_state_t;
  typedef enum logic [1:0] {CIC_RATE_FULL = 2'h0, CIC_RATE_HALF = 2'h1,
                            CIC_RATE_STOP = 2'h2} cic_rate_t;
endpackage

// ### testbench/cic_props.sv
/*
  concurrent checks on the ports of cic_core.
  assumes one clock hclk and the asynchronous active-low reset hresetn.
*/
`timescale 1ns/1ps
module cic_props (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // bus
  input wire logic       hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  // comparators
  input wire logic       adapter_ov,
  input wire logic       adapter_below_det,
  input wire logic       inrush_event,
  input wire logic       die_chg_lim,
  input wire logic       die_chg_shdn,
  input wire logic       chg_below_fifth,
  // controls
  input wire logic       adapter_path_on,
  input wire logic       load_switch_closed,
  input wire logic       charger_on,
  input wire logic       ilim_max,
  input wire logic [2:0] ilim_sel,
  input wire logic       charge_cut_thermal,
  input wire logic       safety_tick,
  input wire logic       irq_n
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0] rd_age;
  wire        rd_take = hsel && hready && htrans[1] && !hwrite;
  // cycles since the last event register read was taken
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rd_age <= 4'hF;
    else if (rd_take && haddr == 8'h14)
      rd_age <= 4'h0;
    else if (rd_age != 4'hF)
      rd_age <= rd_age + 4'h1;
  a_overvoltage_lockout_path_off: assert property (adapter_ov [*7] |-> !adapter_path_on)
    else $error("adapter path still on in lockout");
  a_invalid_switch: assert property (adapter_below_det [*7] |-> load_switch_closed && !charger_on)
    else $error("invalid input left switch open");
  a_irq_release: assert property ($rose(irq_n) |-> rd_age <= 4'h5)
    else $error("irq released without event read");
  a_blank_max: assert property (ilim_max |-> ilim_sel == 3'h7)
    else $error("blanking without maximum limit");
  a_inrush_blank: assert property ($rose(inrush_event) ##1 inrush_event |-> ##[3:5] ilim_max)
    else $error("inrush did not start blanking");
  a_shdn_off: assert property (die_chg_shdn [*7] |-> !adapter_path_on && load_switch_closed)
    else $error("die shutdown still draws adapter");
  a_therm_cut: assert property (die_chg_lim [*7] |-> charge_cut_thermal)
    else $error("die limit without charge cut");
  a_tick_pause: assert property ((die_chg_lim && chg_below_fifth) [*7] |-> !safety_tick)
    else $error("timer ticks while paused");
  a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  c_blank: cover property (ilim_max);
  c_irq: cover property ($fell(irq_n));
  c_tick: cover property (safety_tick);
endmodule
bind cic_core cic_props cic_props_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .adapter_ov, .adapter_below_det, .inrush_event, .die_chg_lim,
  .die_chg_shdn, .chg_below_fifth, .adapter_path_on, .load_switch_closed, .charger_on,
  .ilim_max, .ilim_sel, .charge_cut_thermal, .safety_tick, .irq_n);

// ### testbench/cic_therm_env.sv
/*
  thermistor divider and comparator ladder in front of the block.
  assumes the bench picks a zone 0 cold to 4 hot.
*/
`timescale 1ns/1ps
module cic_therm_env (
  // zone from the bench
  input wire logic [2:0] zone,
  // thermometer code to the block
  output logic     [3:0] therm_cmp
);
  // each warmer zone trips one more comparator
  always_comb therm_cmp = 4'hF >> (3'h4 - zone);
endmodule

// ### testbench/cic_core_tb.sv
/*
  self-checking bench of cic_core.
  assumes the checker bind and the thermistor model are compiled with it.
*/
`timescale 1ns/1ps
`include "cic_defs.svh"
module cic_core_tb;
  import cic_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, zone = 3'h2;
  logic [31:0] hwdata = 0;
  logic adapter_ov = 0, adapter_neg = 0, adapter_below_cell = 0, adapter_below_det = 0;
  logic inrush_event = 0, die_chg_lim = 0, die_chg_shdn = 0, load_rail_limit = 0;
  logic chg_below_half = 0, chg_below_fifth = 0, therm_absent = 0, cell_above_step = 0;
  logic cell_below_hys = 0, cell_above_pre = 0, chg_below_term = 0;
  wire [31:0] hrdata;
  wire [3:0] therm_cmp, load_rail_floor;
  wire [2:0] ilim_sel, fchg_pct, pchg_pct, term_pct;
  wire [1:0] vreg_cut;
  wire hreadyout, hresp, adapter_path_on, load_switch_closed, charger_on, ilim_max;
  wire charge_cut_thermal, charge_cut_load, safety_tick, irq_n;
  wire hready = hreadyout;
  int miscompares = 0, checked = 0;
  logic [63:0] q[$];
  logic rd_pend = 0;
  logic [31:0] rd_last = 0;

  always #5 hclk = ~hclk;

  cic_core #(.TICK_CYC(4)) cic_core_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .adapter_ov, .adapter_neg,
    .adapter_below_cell, .adapter_below_det, .inrush_event, .die_chg_lim, .die_chg_shdn,
    .load_rail_limit, .chg_below_half, .chg_below_fifth, .therm_absent, .therm_cmp,
    .cell_above_step, .cell_below_hys, .cell_above_pre, .chg_below_term, .adapter_path_on,
    .load_switch_closed, .charger_on, .ilim_max, .ilim_sel, .charge_cut_thermal,
    .charge_cut_load, .load_rail_floor, .vreg_cut, .fchg_pct, .pchg_pct, .term_pct,
    .safety_tick, .irq_n);
  cic_therm_env cic_therm_env_inst (.zone, .therm_cmp);

  task end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t pin got %h exp %h", $time, got, exp);
    end
  endtask

  task chk_rd(input logic [31:0] got);
    logic [63:0] e;
    e = {32'hFFFF_FFFF, 32'hXXXX_XXXX};
    if (q.size() != 0)
      e = q.pop_front();
    checked++;
    if ((got & e[63:32]) !== e[31:0])
    begin
      miscompares++;
      $display("BAD %0t read got %h exp %h", $time, got, e[31:0]);
    end
  endtask

  // read data is taken where the data phase ends
  always @(posedge hclk)
  begin
    if (rd_pend && hreadyout)
    begin
      rd_pend = 0;
      rd_last = hrdata;
      chk_rd(hrdata);
      chk(hresp, 0);
    end
    if (hsel && hreadyout && htrans[1] && !hwrite)
      rd_pend = 1;
  end

  task hold;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        miscompares++;
        $display("BAD %0t bus hang", $time);
        end_of_test;
      end
      @(posedge hclk);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge hclk);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    hold;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w)
      q.push_back({m, d});
    hold;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, e, m);
  endtask

  task wt(input int n);
    repeat (n) @(posedge hclk);
  endtask

  initial
  begin
    logic [31:0] r;
    logic [31:0] t0;
    int s, c, d;
    void'($urandom(32'h2656002F));
    wt(2);
    hresetn <= 1'b1;
    chk(load_switch_closed, 1);
    chk(fchg_pct, `CIC_PCT_FULL);
    rd(`CIC_OFS_CTRL, `CIC_CTRL_RST, 32'hFFFF_FFFF);
    rd(`CIC_OFS_ZONEV, `CIC_ZONEV_RST, 32'hFFFF_FFFF);
    rd(`CIC_OFS_ZONEI, `CIC_ZONEI_RST, 32'hFFFF_FFFF);
    rd(`CIC_OFS_STEP, `CIC_STEP_RST, 32'hFFFF_FFFF);
    rd(`CIC_OFS_MASK, `CIC_MASK_RST, 32'hFFFF_FFFF);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0, 32'hFFFF_FFFF);
    // lockout raises the event, reading clears it
    wr(`CIC_OFS_MASK, 32'h7);
    adapter_ov <= 1'b1;
    wt(8);
    chk(adapter_path_on, 0);
    chk(irq_n, 0);
    rd(`CIC_OFS_EVENT, 32'h1, 32'h1);
    wt(2);
    chk(irq_n, 1);
    wr(`CIC_OFS_MASK, 32'h0);
    adapter_ov <= 1'b0;
    wt(8);
    adapter_ov <= 1'b1;
    wt(8);
    chk(irq_n, 1);
    adapter_ov <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      {adapter_neg, adapter_below_cell, adapter_below_det} <= 3'h4 >> i;
      wt(8);
      chk(load_switch_closed, i < 3);
      chk(adapter_path_on, i == 3);
    end
    r = 32'h0000_1C0B | ($urandom() & 32'h003F_0000);
    wr(`CIC_OFS_CTRL, r);
    rd(`CIC_OFS_CTRL, r, 32'h003F_FFFF);
    cell_above_pre <= 1'b1;
    wt(8);
    chk(pchg_pct, r[18:16]);
    chk(term_pct, r[21:19]);
    chk(load_rail_floor, r[11:8]);
    chk(charger_on, 1);
    rd(`CIC_OFS_STATUS, 32'h20, 32'h70);
    // a three-cycle pulse passes the input synchroniser and starts blanking
    inrush_event <= 1'b1;
    wt(3);
    inrush_event <= 1'b0;
    wt(8);
    chk(ilim_sel, `CIC_ILIM_MAX);
    chk(ilim_max, 1);
    wt(110);
    chk(ilim_sel, 3'h3);
    chk(ilim_max, 0);
    // full, half and paused timer rate at four cycles a tick
    for (int m = 0; m < 3; m++)
    begin
      load_rail_limit <= m == 1;
      die_chg_lim <= m == 2;
      chg_below_half <= m != 0;
      chg_below_fifth <= m == 2;
      wt(8);
      chk(charge_cut_load, m == 1);
      chk(charge_cut_thermal, m == 2);
      rd(`CIC_OFS_TIMER, 32'h0, 32'hFFFF_0000);
      wt(1);
      t0 = rd_last;
      // the prescaler tick runs at full rate unless paused
      c = 0;
      repeat (200) @(posedge hclk) c += (safety_tick === 1'b1);
      chk(c >= 49 * (1 - m / 2) && c <= 51 * (1 - m / 2), 1);
      rd(`CIC_OFS_TIMER, 32'h0, 32'hFFFF_0000);
      wt(1);
      // about 205 cycles between the two snapshots, scaled back to full rate
      d = (rd_last - t0) * (m + 1);
      chk(d >= 49 * (1 - m / 2) && d <= 54 * (1 - m / 2), 1);
    end
    {load_rail_limit, die_chg_lim, chg_below_half, chg_below_fifth} <= 4'h0;
    wr(`CIC_OFS_ZONEV, 32'h39);
    wr(`CIC_OFS_ZONEI, 32'h351);
    wr(`CIC_OFS_CTRL, r | 32'hE000);
    for (int z = 0; z < 5; z++)
    begin
      zone <= z[2:0];
      wt(8);
      chk(charger_on, z % 4 != 0);
      rd(`CIC_OFS_STATUS, z << 8, 32'h700);
      if (z % 4 != 0)
      begin
        chk(vreg_cut, z);
        chk(fchg_pct, z == 2 ? 5 : z);
      end
    end
    zone <= 3'h1;
    wr(`CIC_OFS_CTRL, r | 32'hA000);
    wt(8);
    chk(charger_on, 0);
    zone <= 3'h2;
    therm_absent <= 1'b1;
    wt(8);
    chk(charger_on, 0);
    therm_absent <= 1'b0;
    s = $urandom_range(6, 0);
    wr(`CIC_OFS_STEP, s);
    cell_above_step <= 1'b1;
    wt(8);
    chk(fchg_pct, s < 5 ? s : 5);
    rd(`CIC_OFS_STATUS, 32'h800, 32'h800);
    cell_above_step <= 1'b0;
    wt(8);
    chk(fchg_pct, s < 5 ? s : 5);
    cell_below_hys <= 1'b1;
    wt(8);
    chk(fchg_pct, 5);
    wr(`CIC_OFS_STEP, 32'h7);
    cell_above_step <= 1'b1;
    cell_below_hys <= 1'b0;
    wt(8);
    chk(fchg_pct, 5);
    rd(`CIC_OFS_STATUS, 32'h0, 32'h800);
    chg_below_term <= 1'b1;
    wt(8);
    rd(`CIC_OFS_STATUS, 32'h30, 32'h70);
    chk(charger_on, 0);
    die_chg_shdn <= 1'b1;
    wt(8);
    chk(adapter_path_on, 0);
    chk(load_switch_closed, 1);
    end_of_test;
  end
endmodule
